// ==== core/pmat_defs.svh ====
// Constants for the protected-mode address translator.
// Assumes 32-bit linear and physical addresses and 32-bit table entries.
`ifndef PMAT_DEFS_SVH
`define PMAT_DEFS_SVH
`define PMAT_PRESENT_BIT   0
`define PMAT_WRITE_BIT     1
`define PMAT_USER_BIT      2
`define PMAT_PCD_BIT       4
`define PMAT_ACC_BIT       5
`define PMAT_DIRTY_BIT     6
`define PMAT_SEL_TI_BIT    2
`define PMAT_SUPER_MAX_CPL 2'h2
`define PMAT_NUM_SEGS      6
`define PMAT_TLB_ENTRIES   32
`define PMAT_TLB_WAYS      4
`define PMAT_DIR_BASE_RST  32'h00000000
`endif

// ==== core/pmat_pkg.sv ====
// Types shared by the address translator and its surroundings.
// Assumes nothing beyond the constants header.
package pmat_pkg;
    typedef struct packed {
        logic [2:0]  seg;
        logic [31:0] offset;
        logic        write;
        logic [1:0]  current_privilege_level;
    } pmat_req_t;
    typedef struct packed {
        logic [31:0] phys;
        logic        fault;
        logic        nocache;
    } pmat_resp_t;
    typedef struct packed {
        logic        we;
        logic [31:0] addr;
        logic [31:0] wdata;
    } pmat_mem_t;
    typedef struct packed {
        logic [31:0] base;
        logic [19:0] limit;
        logic [7:0]  attr;
    } pmat_seg_t;
    typedef struct packed {
        logic        valid;
        logic [19:0] tag;
        logic [19:0] frame;
        logic        user;
        logic        wr;
        logic        cache_disable_flag;
        logic        dirty;
    } pmat_tlb_t;
    typedef enum logic [7:0] {
        ST_IDLE   = 8'h01,
        ST_DESC0  = 8'h02,
        ST_DESC1  = 8'h04,
        ST_LOOKUP = 8'h08,
        ST_DIR_RD = 8'h10,
        ST_DIR_WR = 8'h20,
        ST_PTE_RD = 8'h40,
        ST_PTE_WR = 8'h80
    } pmat_state_t;
endpackage

// ==== core/pmat_top.sv ====
// Protected-mode address translator: segment cache, paging walk, TLB.
// Assumes core and table memory on mclk; memory answers with a mem_ack pulse.
`include "pmat_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module pmat_top
    import pmat_pkg::*;
#(
    parameter int TLB_ENTRIES = `PMAT_TLB_ENTRIES,
    parameter int TLB_WAYS    = `PMAT_TLB_WAYS
)(
    input  wire logic        mclk,
    input  wire logic        rst_b,
    input  wire logic        req_valid,
    input  wire pmat_req_t   req,
    output logic             req_ready,
    input  wire logic        paging_en,
    input  wire logic        large_page_en,
    input  wire logic        seg_load_valid,
    input  wire logic [2:0]  seg_load_idx,
    input  wire logic [15:0] seg_selector,
    output logic             seg_load_done,
    input  wire logic [31:0] global_descriptor_table_base,
    input  wire logic [31:0] local_descriptor_table_base,
    input  wire logic        dir_base_load,
    input  wire logic [31:0] dir_base_value,
    input  wire logic        single_page_invalidate,
    input  wire logic [31:0] inval_lin_addr,
    output logic             resp_valid,
    output pmat_resp_t       resp,
    output logic             mem_req,
    output pmat_mem_t        mem,
    input  wire logic [31:0] mem_rdata,
    input  wire logic        mem_ack
);
    localparam int SETS = TLB_ENTRIES / TLB_WAYS;
    localparam int SETB = $clog2(SETS);
    localparam int WAYB = $clog2(TLB_WAYS);

    pmat_state_t     st_reg;
    pmat_req_t       req_reg;
    pmat_resp_t      resp_reg;
    pmat_mem_t       mem_reg;
    pmat_seg_t       seg_cache_reg [`PMAT_NUM_SEGS];
    pmat_tlb_t       tlb_reg [TLB_ENTRIES];
    logic [WAYB-1:0] repl_reg [SETS];
    logic [31:0]     directory_base_pointer_reg;
    logic [31:0]     lin_reg;
    logic [31:0]     dir_reg;
    logic [31:0]     desc_lo_reg;
    logic [2:0]      seg_idx_reg;
    logic            req_ready_reg;
    logic            resp_valid_reg;
    logic            seg_done_reg;
    logic            mem_req_reg;
    logic [31:0]     lin_next;
    logic [31:0]     desc_tbl;
    logic [SETB-1:0] set_idx;
    logic [SETB-1:0] inv_set;
    logic            tlb_hit;
    logic [WAYB-1:0] hit_way;
    pmat_tlb_t       hit_ent;
    logic            tlb_use;
    logic            user_lvl;
    logic            pte_user;
    logic            pte_wr;
    logic            pte_bad;
    logic            pte_upd;
    logic            install;
    pmat_tlb_t       new_ent;

    assign req_ready     = req_ready_reg;
    assign resp_valid    = resp_valid_reg;
    assign resp          = resp_reg;
    assign seg_load_done = seg_done_reg;
    assign mem_req       = mem_req_reg;
    assign mem           = mem_reg;

    // Linear address from the hidden segment base; unknown segments use base zero.
    assign lin_next = ((req.seg < 3'(`PMAT_NUM_SEGS)) ? seg_cache_reg[req.seg].base
                      : 32'h00000000) + req.offset;
    assign desc_tbl = seg_selector[`PMAT_SEL_TI_BIT] ? local_descriptor_table_base
                      : global_descriptor_table_base;
    assign set_idx  = lin_reg[12 +: SETB];
    assign inv_set  = inval_lin_addr[12 +: SETB];
    assign user_lvl = req_reg.current_privilege_level > `PMAT_SUPER_MAX_CPL;

    // Associative search of one set. The TLB never watches table writes,
    // so stale entries stay until software flushes them.
    always_comb
    begin
        tlb_hit = 1'b0;
        hit_way = '0;
        hit_ent = '0;
        for (int w = 0; w < TLB_WAYS; w++)
        begin
            if (tlb_reg[int'(set_idx) * TLB_WAYS + w].valid &&
                tlb_reg[int'(set_idx) * TLB_WAYS + w].tag == lin_reg[31:12])
            begin
                tlb_hit = 1'b1;
                hit_way = WAYB'(w);
                hit_ent = tlb_reg[int'(set_idx) * TLB_WAYS + w];
            end
        end
    end

    // A hit is usable unless a first write must still mark the page dirty.
    assign tlb_use = tlb_hit && !(req_reg.write && !hit_ent.dirty);

    // Page entry checks combine directory and page permissions.
    assign pte_user = dir_reg[`PMAT_USER_BIT] & mem_rdata[`PMAT_USER_BIT];
    assign pte_wr   = dir_reg[`PMAT_WRITE_BIT] & mem_rdata[`PMAT_WRITE_BIT];
    assign pte_bad  = (user_lvl && !pte_user) || (req_reg.write && !pte_wr);
    assign pte_upd  = !mem_rdata[`PMAT_ACC_BIT] ||
                      (req_reg.write && !mem_rdata[`PMAT_DIRTY_BIT]);
    assign install  = mem_ack && ((st_reg == ST_PTE_WR) || ((st_reg == ST_PTE_RD) &&
                      mem_rdata[`PMAT_PRESENT_BIT] && !pte_bad && !pte_upd));

    // Entry to install; after a write-back the written word is the truth.
    always_comb
    begin
        new_ent       = '0;
        new_ent.valid = 1'b1;
        new_ent.tag   = lin_reg[31:12];
        if (st_reg == ST_PTE_WR)
        begin
            new_ent.frame = mem_reg.wdata[31:12];
            new_ent.dirty = mem_reg.wdata[`PMAT_DIRTY_BIT];
            new_ent.cache_disable_flag   = mem_reg.wdata[`PMAT_PCD_BIT] | dir_reg[`PMAT_PCD_BIT];
            new_ent.user  = dir_reg[`PMAT_USER_BIT] & mem_reg.wdata[`PMAT_USER_BIT];
            new_ent.wr    = dir_reg[`PMAT_WRITE_BIT] & mem_reg.wdata[`PMAT_WRITE_BIT];
        end
        else
        begin
            new_ent.frame = mem_rdata[31:12];
            new_ent.dirty = mem_rdata[`PMAT_DIRTY_BIT];
            new_ent.cache_disable_flag   = mem_rdata[`PMAT_PCD_BIT] | dir_reg[`PMAT_PCD_BIT];
            new_ent.user  = pte_user;
            new_ent.wr    = pte_wr;
        end
    end

    // Directory base register; loading it also flushes the TLB below.
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            directory_base_pointer_reg <= `PMAT_DIR_BASE_RST;
        else if (dir_base_load)
            directory_base_pointer_reg <= dir_base_value;
    end

    // TLB storage. A flush wins over a same-cycle install, since the
    // walk may have used tables from the old directory.
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            for (int i = 0; i < TLB_ENTRIES; i++)
                tlb_reg[i] <= '0;
            for (int s = 0; s < SETS; s++)
                repl_reg[s] <= '0;
        end
        else if (dir_base_load)
        begin
            for (int i = 0; i < TLB_ENTRIES; i++)
                tlb_reg[i].valid <= 1'b0;
        end
        else
        begin
            if (install)
            begin
                tlb_reg[int'(set_idx) * TLB_WAYS +
                        int'(tlb_hit ? hit_way : repl_reg[set_idx])] <= new_ent;
                if (!tlb_hit)
                    repl_reg[set_idx] <= repl_reg[set_idx] + 1'b1;
            end
            if (single_page_invalidate)
            begin
                for (int w = 0; w < TLB_WAYS; w++)
                begin
                    if (tlb_reg[int'(inv_set) * TLB_WAYS + w].tag == inval_lin_addr[31:12])
                        tlb_reg[int'(inv_set) * TLB_WAYS + w].valid <= 1'b0;
                end
            end
        end
    end

    // Hidden segment descriptor cache, filled by the second descriptor word.
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            for (int i = 0; i < `PMAT_NUM_SEGS; i++)
                seg_cache_reg[i] <= '0;
        end
        else if (st_reg == ST_DESC1 && mem_ack && seg_idx_reg < 3'(`PMAT_NUM_SEGS))
        begin
            seg_cache_reg[seg_idx_reg].base  <= {mem_rdata[31:24], mem_rdata[7:0],
                                                 desc_lo_reg[31:16]};
            seg_cache_reg[seg_idx_reg].limit <= {mem_rdata[19:16], desc_lo_reg[15:0]};
            seg_cache_reg[seg_idx_reg].attr  <= mem_rdata[15:8];
        end
    end

    // Sequencer: descriptor fetch, lookup, walk and answer. Write-backs only
    // OR in flag bits, so ignored and reserved bits survive.
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            st_reg         <= ST_IDLE;
            req_reg        <= '0;
            resp_reg       <= '0;
            mem_reg        <= '0;
            lin_reg        <= 32'h00000000;
            dir_reg        <= 32'h00000000;
            desc_lo_reg    <= 32'h00000000;
            seg_idx_reg    <= 3'h0;
            req_ready_reg  <= 1'b1;
            resp_valid_reg <= 1'b0;
            seg_done_reg   <= 1'b0;
            mem_req_reg    <= 1'b0;
        end
        else
        begin
            resp_valid_reg <= 1'b0;
            seg_done_reg   <= 1'b0;
            if (mem_ack)
                mem_req_reg <= 1'b0;
            unique case (st_reg)
                ST_IDLE:
                    if (req_ready_reg && seg_load_valid)
                    begin
                        seg_idx_reg   <= seg_load_idx;
                        mem_req_reg   <= 1'b1;
                        mem_reg       <= '{1'b0, desc_tbl + {16'h0000, seg_selector[15:3],
                                           3'h0}, 32'h00000000};
                        req_ready_reg <= 1'b0;
                        st_reg        <= ST_DESC0;
                    end
                    else if (req_ready_reg && req_valid)
                    begin
                        req_reg       <= req;
                        lin_reg       <= lin_next;
                        req_ready_reg <= 1'b0;
                        st_reg        <= ST_LOOKUP;
                    end
                ST_DESC0:
                    if (mem_ack)
                    begin
                        desc_lo_reg   <= mem_rdata;
                        mem_req_reg   <= 1'b1;
                        mem_reg.addr  <= mem_reg.addr + 32'h00000004;
                        st_reg        <= ST_DESC1;
                    end
                ST_DESC1:
                    if (mem_ack)
                    begin
                        seg_done_reg  <= 1'b1;
                        req_ready_reg <= 1'b1;
                        st_reg        <= ST_IDLE;
                    end
                ST_LOOKUP:
                    if (!paging_en)
                    begin
                        resp_reg       <= '{lin_reg, 1'b0, 1'b0};
                        resp_valid_reg <= 1'b1;
                        req_ready_reg  <= 1'b1;
                        st_reg         <= ST_IDLE;
                    end
                    else if (tlb_use)
                    begin
                        resp_reg.phys    <= {hit_ent.frame, lin_reg[11:0]};
                        resp_reg.fault   <= (user_lvl && !hit_ent.user) ||
                                            (req_reg.write && !hit_ent.wr);
                        resp_reg.nocache <= hit_ent.cache_disable_flag;
                        resp_valid_reg   <= 1'b1;
                        req_ready_reg    <= 1'b1;
                        st_reg           <= ST_IDLE;
                    end
                    else
                    begin
                        mem_req_reg <= 1'b1;
                        mem_reg     <= '{1'b0, {directory_base_pointer_reg[31:12],
                                         lin_reg[31:22], 2'b00}, 32'h00000000};
                        st_reg      <= ST_DIR_RD;
                    end
                ST_DIR_RD:
                    if (mem_ack)
                    begin
                        dir_reg <= mem_rdata;
                        if (!mem_rdata[`PMAT_PRESENT_BIT] || (large_page_en &&
                            ((user_lvl && !mem_rdata[`PMAT_USER_BIT]) ||
                             (req_reg.write && !mem_rdata[`PMAT_WRITE_BIT]))))
                        begin
                            resp_reg       <= '{32'h00000000, 1'b1, 1'b0};
                            resp_valid_reg <= 1'b1;
                            req_ready_reg  <= 1'b1;
                            st_reg         <= ST_IDLE;
                        end
                        else if (!mem_rdata[`PMAT_ACC_BIT])
                        begin
                            mem_req_reg   <= 1'b1;
                            mem_reg.we    <= 1'b1;
                            mem_reg.wdata <= mem_rdata | (32'h1 << `PMAT_ACC_BIT);
                            st_reg        <= ST_DIR_WR;
                        end
                        else if (large_page_en)
                        begin
                            // 1 MByte pages are not kept in the TLB.
                            resp_reg       <= '{{mem_rdata[31:20], lin_reg[19:0]}, 1'b0,
                                                mem_rdata[`PMAT_PCD_BIT]};
                            resp_valid_reg <= 1'b1;
                            req_ready_reg  <= 1'b1;
                            st_reg         <= ST_IDLE;
                        end
                        else
                        begin
                            mem_req_reg <= 1'b1;
                            mem_reg     <= '{1'b0, {mem_rdata[31:12], lin_reg[21:12],
                                             2'b00}, 32'h00000000};
                            st_reg      <= ST_PTE_RD;
                        end
                    end
                ST_DIR_WR:
                    if (mem_ack && large_page_en)
                    begin
                        resp_reg       <= '{{dir_reg[31:20], lin_reg[19:0]}, 1'b0,
                                            dir_reg[`PMAT_PCD_BIT]};
                        resp_valid_reg <= 1'b1;
                        req_ready_reg  <= 1'b1;
                        st_reg         <= ST_IDLE;
                    end
                    else if (mem_ack)
                    begin
                        mem_req_reg <= 1'b1;
                        mem_reg     <= '{1'b0, {dir_reg[31:12], lin_reg[21:12], 2'b00},
                                         32'h00000000};
                        st_reg      <= ST_PTE_RD;
                    end
                ST_PTE_RD:
                    if (mem_ack && (!mem_rdata[`PMAT_PRESENT_BIT] || pte_bad))
                    begin
                        resp_reg       <= '{32'h00000000, 1'b1, 1'b0};
                        resp_valid_reg <= 1'b1;
                        req_ready_reg  <= 1'b1;
                        st_reg         <= ST_IDLE;
                    end
                    else if (mem_ack && pte_upd)
                    begin
                        mem_req_reg   <= 1'b1;
                        mem_reg.we    <= 1'b1;
                        mem_reg.wdata <= mem_rdata | (32'h1 << `PMAT_ACC_BIT) |
                                         (req_reg.write ? (32'h1 << `PMAT_DIRTY_BIT)
                                          : 32'h0);
                        st_reg        <= ST_PTE_WR;
                    end
                    else if (mem_ack)
                    begin
                        resp_reg       <= '{{mem_rdata[31:12], lin_reg[11:0]}, 1'b0,
                                            new_ent.cache_disable_flag};
                        resp_valid_reg <= 1'b1;
                        req_ready_reg  <= 1'b1;
                        st_reg         <= ST_IDLE;
                    end
                ST_PTE_WR:
                    if (mem_ack)
                    begin
                        resp_reg       <= '{{mem_reg.wdata[31:12], lin_reg[11:0]}, 1'b0,
                                            new_ent.cache_disable_flag};
                        resp_valid_reg <= 1'b1;
                        req_ready_reg  <= 1'b1;
                        st_reg         <= ST_IDLE;
                    end
            endcase
        end
    end

    // Checks on the translation sequence.
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    sequence s_accept;
        st_reg == ST_IDLE && req_ready_reg && req_valid && !seg_load_valid;
    endsequence
    sequence s_miss_walk;
        st_reg == ST_LOOKUP && paging_en && !tlb_use;
    endsequence
    sequence s_dir_absent;
        st_reg == ST_DIR_RD && mem_ack && !mem_rdata[`PMAT_PRESENT_BIT];
    endsequence

    property p_lin_sum;
        s_accept |=> lin_reg == $past(lin_next);
    endproperty
    a_lin_sum: assert property (p_lin_sum) else $error("linear sum wrong");
    property p_flat;
        st_reg == ST_LOOKUP && !paging_en |=> resp_valid_reg && resp_reg.phys == $past(lin_reg);
    endproperty
    a_flat: assert property (p_flat) else $error("flat address wrong");
    property p_offset;
        resp_valid_reg && !resp_reg.fault |-> resp_reg.phys[11:0] == lin_reg[11:0];
    endproperty
    a_offset: assert property (p_offset) else $error("page offset altered");
    property p_dir_addr;
        s_miss_walk ##0 !dir_base_load |=> mem_req_reg && !mem_reg.we &&
            mem_reg.addr == {directory_base_pointer_reg[31:12], lin_reg[31:22], 2'b00};
    endproperty
    a_dir_addr: assert property (p_dir_addr) else $error("directory address wrong");
    property p_pte_addr;
        st_reg == ST_PTE_RD && mem_req_reg |->
            mem_reg.addr == {dir_reg[31:12], lin_reg[21:12], 2'b00};
    endproperty
    a_pte_addr: assert property (p_pte_addr) else $error("page entry address wrong");
    property p_absent;
        s_dir_absent |=> resp_valid_reg && resp_reg.fault && req_ready_reg;
    endproperty
    a_absent: assert property (p_absent) else $error("missing page fault");
    property p_flush;
        dir_base_load |=> !tlb_reg[0].valid && !tlb_reg[TLB_ENTRIES-1].valid;
    endproperty
    a_flush: assert property (p_flush) else $error("TLB not flushed");
    property p_acc;
        st_reg == ST_DIR_WR && mem_req_reg |-> mem_reg.we && mem_reg.wdata[`PMAT_ACC_BIT];
    endproperty
    a_acc: assert property (p_acc) else $error("accessed bit not set");
    property p_dirty;
        st_reg == ST_PTE_WR && mem_req_reg && req_reg.write |->
            mem_reg.wdata[`PMAT_DIRTY_BIT] && mem_reg.wdata[`PMAT_ACC_BIT];
    endproperty
    a_dirty: assert property (p_dirty) else $error("dirty bit not set");
endmodule
`default_nettype wire

// ==== verification/pmat_mem_model.sv ====
// Table memory model that answers the translator after a chosen lag.
// Assumes mclk is shared; the bench preloads words and peeks write-backs.
`timescale 1ns/1ps
`default_nettype none
module pmat_mem_model
    import pmat_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        mem_req,
    input  wire pmat_mem_t   mem,
    output logic [31:0]      mem_rdata,
    output logic             mem_ack,
    input  wire logic [1:0]  lag,
    input  wire logic        ld_en,
    input  wire logic [31:0] ld_addr,
    input  wire logic [31:0] ld_data,
    input  wire logic [31:0] pk_addr,
    output logic [31:0]      pk_data
);
    logic [31:0] m [logic [31:0]];
    logic [1:0]  wait_reg = 2'h0;
    initial mem_ack = 1'b0;
    initial mem_rdata = 32'h0;
    // Read data flips outside an ack, so a stale word is never mistaken for an answer.
    always @(posedge mclk)
    begin
        pk_data <= m.exists(pk_addr) ? m[pk_addr] : 32'h0;
        mem_ack <= 1'b0;
        mem_rdata <= ~mem_rdata;
        if (ld_en)
            m[ld_addr] = ld_data;
        if (mem_req && !mem_ack && wait_reg >= lag)
        begin
            mem_ack <= 1'b1;
            mem_rdata <= m.exists(mem.addr) ? m[mem.addr] : 32'h0;
            if (mem.we)
                m[mem.addr] = mem.wdata;
            wait_reg <= 2'h0;
        end
        else if (mem_req && !mem_ack)
            wait_reg <= wait_reg + 2'h1;
    end
endmodule
`default_nettype wire

// ==== verification/pmat_top_bench.sv ====
// Bench for the translator: core stimulus, table memory model, result queue.
// Assumes pmat_pkg, pmat_top and pmat_mem_model are compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin err_count++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module pmat_top_bench
    import pmat_pkg::*;
;
    logic mclk, rst_b, req_valid, req_ready, paging_en, seg_load_valid, seg_load_done;
    logic dir_base_load, single_page_invalidate, resp_valid, mem_req, mem_ack, ld_en;
    logic [2:0] seg_load_idx;
    logic [15:0] seg_selector;
    logic [31:0] dir_base_value, inval_lin_addr, mem_rdata, ld_addr, ld_data, pk_addr;
    logic [31:0] pk_data, off;
    logic [1:0] lag;
    logic large_page_en;
    pmat_req_t req;
    pmat_resp_t resp, exp_r;
    pmat_mem_t mem;
    pmat_resp_t exp_q[$];
    int err_count, cmp_count, acks, a0, cyc;
    pmat_top pmat_top_i (.mclk, .rst_b, .req_valid, .req, .req_ready, .paging_en,
        .large_page_en, .seg_load_valid, .seg_load_idx, .seg_selector, .seg_load_done,
        .global_descriptor_table_base(32'h00002000), .local_descriptor_table_base(32'h00003000),
        .dir_base_load, .dir_base_value, .single_page_invalidate, .inval_lin_addr,
        .resp_valid, .resp, .mem_req, .mem, .mem_rdata, .mem_ack);
    pmat_mem_model pmat_mem_model_i (.mclk, .mem_req, .mem, .mem_rdata, .mem_ack, .lag,
        .ld_en, .ld_addr, .ld_data, .pk_addr, .pk_data);
    task automatic complete_run();
        err_count += exp_q.size();
        $display("Counts: compares=%0d mismatches=%0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic poke(input logic [31:0] a, input logic [31:0] d);
        ld_en <= 1'b1;
        ld_addr <= a;
        ld_data <= d;
        @(posedge mclk);
        ld_en <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic peek(input logic [31:0] a, input logic [31:0] e);
        pk_addr <= a;
        repeat (2) @(posedge mclk);
        `CHK(pk_data, e)
    endtask
    task automatic pulse_dir();
        dir_base_value <= 32'h00010000;
        dir_base_load <= 1'b1;
        @(posedge mclk);
        dir_base_load <= 1'b0;
    endtask
    // Notes the expected answer, holds the request until taken, then waits for it.
    task automatic xlat(input logic [2:0] s, input logic [31:0] o, input logic w,
                        input logic [1:0] c, input pmat_resp_t e);
        exp_q.push_back(e);
        req_valid <= 1'b1;
        req <= '{s, o, w, c};
        lag <= 2'($urandom);
        @(posedge mclk);
        while (!req_ready) @(posedge mclk);
        req_valid <= 1'b0;
        repeat (60) if (exp_q.size() != 0) @(posedge mclk);
    endtask
    initial
    begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    // Each answer is matched against the oldest note; counts acks and cuts a hang.
    always @(posedge mclk)
    begin
        cyc++;
        if (mem_ack === 1'b1)
            acks++;
        if (resp_valid === 1'b1)
        begin
            exp_r = exp_q.size() ? exp_q.pop_front() : '1;
            `CHK(resp, exp_r)
        end
        if (cyc == 5000)
        begin
            err_count++;
            complete_run();
        end
    end
    // Main sequence: reset, segment load, then paging cases.
    initial
    begin
        {rst_b, req_valid, paging_en, seg_load_valid, dir_base_load, ld_en, lag, req} = '0;
        {single_page_invalidate, seg_load_idx, seg_selector, dir_base_value} = '0;
        {inval_lin_addr, ld_addr, ld_data, pk_addr, large_page_en} = '0;
        void'($urandom(54));
        repeat (2) @(posedge mclk);
        rst_b <= 1'b1;
        poke(32'h00002018, 32'h5000FFFF);
        poke(32'h0000201C, 32'h120F9234);
        seg_load_valid <= 1'b1;
        seg_load_idx <= 3'h1;
        seg_selector <= 16'h0018;
        @(posedge mclk);
        seg_load_valid <= 1'b0;
        repeat (40) if (seg_load_done !== 1'b1) @(posedge mclk);
        `CHK(seg_load_done, 1'b1)
        for (int i = 0; i < 4; i++)
        begin
            off = $urandom;
            xlat(3'h7, off, off[0], 2'h3, '{off, 1'b0, 1'b0});
            xlat(3'h1, off, 1'b0, 2'h0, '{off + 32'h12345000, 1'b0, 1'b0});
        end
        $display("Test segment and paging off done");
        paging_en <= 1'b1;
        pulse_dir();
        poke(32'h00010004, 32'h00020007);
        poke(32'h0002000C, 32'h00055E17);
        poke(32'h00020010, 32'h00066002);
        poke(32'h00020014, 32'h00077021);
        xlat(3'h7, 32'h00403ABC, 1'b0, 2'h3, '{32'h00055ABC, 1'b0, 1'b1});
        peek(32'h00010004, 32'h00020027);
        peek(32'h0002000C, 32'h00055E37);
        xlat(3'h7, 32'h00403ABC, 1'b1, 2'h3, '{32'h00055ABC, 1'b0, 1'b1});
        peek(32'h0002000C, 32'h00055E77);
        a0 = acks;
        xlat(3'h7, 32'h00403ABC, 1'b0, 2'h3, '{32'h00055ABC, 1'b0, 1'b1});
        `CHK(acks, a0)
        $display("Test walk and hit done");
        xlat(3'h7, 32'h00404ABC, 1'b0, 2'h0, '{32'h0, 1'b1, 1'b0});
        xlat(3'h7, 32'h00405123, 1'b0, 2'h3, '{32'h0, 1'b1, 1'b0});
        xlat(3'h7, 32'h00405123, 1'b0, 2'h0, '{32'h00077123, 1'b0, 1'b0});
        xlat(3'h7, 32'h00405123, 1'b1, 2'h0, '{32'h0, 1'b1, 1'b0});
        xlat(3'h7, 32'h00800000, 1'b0, 2'h0, '{32'h0, 1'b1, 1'b0});
        // A large page whose directory entry still needs its accessed bit set.
        poke(32'h0001000C, 32'h00700007);
        large_page_en <= 1'b1;
        xlat(3'h7, 32'h00C12345, 1'b0, 2'h3, '{32'h00712345, 1'b0, 1'b0});
        large_page_en <= 1'b0;
        $display("Test protection done");
        poke(32'h0002000C, 32'h00088E67);
        xlat(3'h7, 32'h00403ABC, 1'b0, 2'h3, '{32'h00055ABC, 1'b0, 1'b1});
        pulse_dir();
        xlat(3'h7, 32'h00403ABC, 1'b0, 2'h3, '{32'h00088ABC, 1'b0, 1'b0});
        // Refill the other page after the flush, so the invalidate below must spare it.
        xlat(3'h7, 32'h00405123, 1'b0, 2'h0, '{32'h00077123, 1'b0, 1'b0});
        poke(32'h0002000C, 32'h00099067);
        single_page_invalidate <= 1'b1;
        inval_lin_addr <= 32'h00403000;
        @(posedge mclk);
        single_page_invalidate <= 1'b0;
        a0 = acks;
        xlat(3'h7, 32'h00405123, 1'b0, 2'h0, '{32'h00077123, 1'b0, 1'b0});
        `CHK(acks, a0)
        xlat(3'h7, 32'h00403ABC, 1'b0, 2'h3, '{32'h00099ABC, 1'b0, 1'b0});
        $display("Test flush done");
        complete_run();
    end
endmodule
`default_nettype wire
